// File: rtl/sdcfl_core.sv
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - History of ten faults, zero newest
// - Report present faults and history
// - Clear present faults, keep history
// - Clear everything clears faults and history
// - Current limit fault from over-current sense
// - Supply high fault from supply monitor
// - Coil wiring fault from wiring detect
// - Switch four double change starts self-identify
// - Peak current accepted from 0.1 to 3.2
// - Microsteps accepted from 1 to 512
// - Selectable step/direction or dual pulse
// - Selectable rising or falling step edge
// - Dual pulse ignores fixed-level input
// - Anti-resonance off when all zero
// - Three resonance areas with capturable limits
// - Defaults: areas one, two zero; three 128
// - Step angle is detected, not set
// - PI gains writable; step test supported
// - Tuning link defaults to 38400 baud
// - Persist parameters and load defaults
// - Internal pulse generator for test motion
// - Fault latches motor off until power cycle
module sdcfl_core
    import sdcfl_pkg::*;
#(
    parameter int TOGGLE_WINDOW = DOUBLE_TOGGLE_CYC
) (
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Step command inputs.
    input  wire logic        step_pulse_in,
    input  wire logic        direction_in,
    // Setting switches and sensors.
    input  wire logic        setting_switch_four,
    input  wire logic        over_current_sense,
    input  wire logic        supply_high_sense,
    input  wire logic        wiring_bad_sense,
    input  wire logic        identify_done,
    input  wire logic [7:0]  detected_step_angle,
    // Drive outputs.
    output logic             step_out,
    output logic             dir_out,
    output logic             motor_enable,
    output logic             anti_res_enable,
    output logic             identify_start,
    output logic             step_test_start,
    output logic             persist_parameters
);

    // Configuration registers.
    logic [15:0] peak_q;
    logic [15:0] micro_q;
    logic [15:0] prop_gain_q;
    logic [15:0] int_gain_q;
    logic [15:0] baud_div_q;
    logic [15:0] pulse_rate_q;
    logic        format_q;           // Zero step/direction, one dual pulse.
    logic        edge_q;             // Zero rising, one falling.
    logic        gen_run_q;          // Internal generator enable.
    sdcfl_res_s  res_q [3];          // Resonance areas.
    logic [7:0]  step_angle_q;       // Detected step angle.
    // Fault state.
    logic [2:0]  fault_q;            // Present flags: current, supply, wiring.
    logic        latched_q;          // Fault latch until power cycle.
    // Generator and switch tracking.
    logic [15:0] gen_cnt_q;
    logic        gen_tick_q;
    logic        sw_prev_q;
    logic        sw_armed_q;
    logic [31:0] sw_cnt_q;
    logic        identify_busy_q;
    // Request decode.
    sdcfl_req_s  req;
    logic        wr_ctl;
    logic [2:0]  new_fault;
    logic [2:0]  hist_code;
    logic        step_edge;
    logic        dir_edge;
    logic        speed_cap;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign wr_ctl = req.wr && (req.addr[4:0] == ADDR_CONTROL) && (req.addr[7:5] == 3'h0);

    // Configuration writes, with range limits and default loading.
    always_ff @(posedge core_clk) begin
        if (reset || (wr_ctl && req.wdata[CTL_LOAD_DEF])) begin
            peak_q       <= PEAK_DEFAULT;
            micro_q      <= MICRO_DEFAULT;
            prop_gain_q  <= 16'h0000;
            int_gain_q   <= 16'h0000;
            baud_div_q   <= BAUD_DIV_DEF;
            pulse_rate_q <= 16'h0000;
            format_q     <= 1'b0;
            edge_q       <= 1'b0;
            gen_run_q    <= 1'b0;
        end else if (req.wr && req.addr[7:5] == 3'h0) begin
            case (req.addr[4:0])
                ADDR_CONTROL: begin
                    format_q  <= req.wdata[CTL_FORMAT];
                    edge_q    <= req.wdata[CTL_EDGE];
                    gen_run_q <= req.wdata[CTL_GEN_RUN];
                end
                ADDR_PEAK: begin
                    if (req.wdata >= PEAK_MIN && req.wdata <= PEAK_MAX) begin
                        peak_q <= req.wdata;
                    end
                end
                ADDR_MICROSTEP: begin
                    if (req.wdata >= MICRO_MIN && req.wdata <= MICRO_MAX) begin
                        micro_q <= req.wdata;
                    end
                end
                ADDR_PROP_GAIN: prop_gain_q <= req.wdata;
                ADDR_INT_GAIN: int_gain_q <= req.wdata;
                ADDR_BAUD_DIV: baud_div_q <= req.wdata;
                ADDR_PULSE_RATE: pulse_rate_q <= req.wdata;
                default: ;
            endcase
        end
    end

    // Capture request: the generator period stands for the present speed.
    assign speed_cap = wr_ctl && req.wdata[CTL_CAPTURE];

    // Resonance areas: defaults, writes and limit capture.
    always_ff @(posedge core_clk) begin
        if (reset || (wr_ctl && req.wdata[CTL_LOAD_DEF])) begin
            for (int a = 0; a < 3; a++) begin
                res_q[a] <= '0;
                res_q[a].amplitude <= (a == 2) ? RES_DEF_THREE : RES_DEF_ZERO;
                res_q[a].phase     <= (a == 2) ? RES_DEF_THREE : RES_DEF_ZERO;
            end
        end else if (speed_cap && req.wdata[CTL_CAP_AREA +: 2] != 2'h3) begin
            if (req.wdata[CTL_CAP_UPPER]) begin
                res_q[req.wdata[CTL_CAP_AREA +: 2]].speed_ceiling <= pulse_rate_q;
            end else begin
                res_q[req.wdata[CTL_CAP_AREA +: 2]].speed_floor <= pulse_rate_q;
            end
        end else if (req.wr && req.addr[4] && req.addr[7:5] == 3'h0
                     && req.addr[3:2] != 2'h3) begin
            case (req.addr[1:0])
                2'h0: res_q[req.addr[3:2]].amplitude <= req.wdata;
                2'h1: res_q[req.addr[3:2]].phase <= req.wdata;
                2'h2: res_q[req.addr[3:2]].speed_floor <= req.wdata;
                default: res_q[req.addr[3:2]].speed_ceiling <= req.wdata;
            endcase
        end
    end

    // Anti-resonance runs when any amplitude or phase is nonzero.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            anti_res_enable <= 1'b0;
        end else begin
            anti_res_enable <= (|res_q[0].amplitude) | (|res_q[0].phase)
                             | (|res_q[1].amplitude) | (|res_q[1].phase)
                             | (|res_q[2].amplitude) | (|res_q[2].phase);
        end
    end

    // Present faults: sensors set, commands clear, set wins.
    assign new_fault = {wiring_bad_sense, supply_high_sense, over_current_sense} & ~fault_q;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fault_q <= 3'h0;
        end else begin
            if (wr_ctl && (req.wdata[CTL_CLR_PRESENT] || req.wdata[CTL_CLR_ALL])) begin
                fault_q <= {wiring_bad_sense, supply_high_sense, over_current_sense};
            end else begin
                fault_q <= fault_q | {wiring_bad_sense,
                                      supply_high_sense,
                                      over_current_sense};
            end
        end
    end

    // Protection latch; only reset (power cycle) releases it.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            latched_q    <= 1'b0;
            motor_enable <= 1'b0;
        end else begin
            latched_q    <= latched_q | (|new_fault);
            motor_enable <= ~(latched_q | (|new_fault));
        end
    end

    // History keeps the lowest-numbered new fault of a cycle.
    sdcfl_fault_history #(.DEPTH(10)) u_hist (
        .core_clk (core_clk),
        .reset    (reset),
        .push     (|new_fault),
        .code     (new_fault[0] ? SDCFL_FLT_CURRENT :
                   new_fault[1] ? SDCFL_FLT_SUPPLY : SDCFL_FLT_WIRING),
        .clear_all(wr_ctl && req.wdata[CTL_CLR_ALL]),
        .rd_index (4'(req.addr - ADDR_HIST_WIN)),
        .rd_code  (hist_code)
    );

    // Internal pulse generator for test motion.
    always_ff @(posedge core_clk) begin
        if (reset || !gen_run_q) begin
            gen_cnt_q  <= 16'h0000;
            gen_tick_q <= 1'b0;
        end else if (gen_cnt_q >= pulse_rate_q) begin
            gen_cnt_q  <= 16'h0000;
            gen_tick_q <= ~gen_tick_q;
        end else begin
            gen_cnt_q  <= gen_cnt_q + 16'h0001;
        end
    end

    // Edge pickers on the step input and the counterclockwise input.
    sdcfl_edge_detect u_step (
        .core_clk  (core_clk),
        .reset     (reset),
        .level     (gen_run_q ? gen_tick_q : step_pulse_in),
        .falling   (edge_q),
        .edge_pulse(step_edge)
    );
    sdcfl_edge_detect u_dir (
        .core_clk  (core_clk),
        .reset     (reset),
        .level     (direction_in),
        .falling   (edge_q),
        .edge_pulse(dir_edge)
    );

    // Step output per command format.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            step_out <= 1'b0;
            dir_out  <= 1'b0;
        end else if (format_q && !gen_run_q) begin
            step_out <= (step_edge | dir_edge) & motor_enable;
            if (step_edge) begin
                dir_out <= 1'b0;
            end else if (dir_edge) begin
                dir_out <= 1'b1;
            end
        end else begin
            step_out <= step_edge & motor_enable;
            dir_out  <= gen_run_q ? 1'b0 : direction_in;
        end
    end

    // Switch four double change within the window starts self-identify.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sw_prev_q       <= 1'b0;
            sw_armed_q      <= 1'b0;
            sw_cnt_q        <= 32'h0;
            identify_start  <= 1'b0;
            identify_busy_q <= 1'b0;
            step_angle_q    <= 8'h00;
        end else begin
            sw_prev_q      <= setting_switch_four;
            identify_start <= 1'b0;
            if (sw_armed_q && 32'(sw_cnt_q) < 32'(TOGGLE_WINDOW)) begin
                sw_cnt_q <= sw_cnt_q + 32'h1;
            end else begin
                sw_armed_q <= 1'b0;
            end
            // Done comes first so that a start in the same cycle wins.
            if (identify_busy_q && identify_done) begin
                identify_busy_q <= 1'b0;
                step_angle_q    <= detected_step_angle;
            end
            if (setting_switch_four != sw_prev_q) begin
                if (sw_armed_q && 32'(sw_cnt_q) < 32'(TOGGLE_WINDOW)) begin
                    sw_armed_q      <= 1'b0;
                    identify_start  <= 1'b1;
                    identify_busy_q <= 1'b1;
                end else begin
                    sw_armed_q <= 1'b1;
                    sw_cnt_q   <= 32'h0;
                end
            end
        end
    end

    // Command pulses for step test and persisting parameters.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            step_test_start    <= 1'b0;
            persist_parameters <= 1'b0;
        end else begin
            step_test_start    <= wr_ctl && req.wdata[CTL_STEP_TEST];
            persist_parameters <= wr_ctl && req.wdata[CTL_PERSIST];
        end
    end

    // Read data, valid in the cycle after the read strobe.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (req.rd) begin
            reg_rdata <= 16'h0000;
            if (req.addr >= ADDR_HIST_WIN) begin
                reg_rdata <= {13'h0, hist_code};
            end else if (req.addr[4] && req.addr[3:2] != 2'h3) begin
                case (req.addr[1:0])
                    2'h0: reg_rdata <= res_q[req.addr[3:2]].amplitude;
                    2'h1: reg_rdata <= res_q[req.addr[3:2]].phase;
                    2'h2: reg_rdata <= res_q[req.addr[3:2]].speed_floor;
                    default: reg_rdata <= res_q[req.addr[3:2]].speed_ceiling;
                endcase
            end else begin
                case (req.addr[4:0])
                    ADDR_CONTROL: reg_rdata <= {8'h0, gen_run_q, 3'h0, edge_q, format_q, 2'h0};
                    ADDR_PEAK: reg_rdata <= peak_q;
                    ADDR_MICROSTEP: reg_rdata <= micro_q;
                    ADDR_PROP_GAIN: reg_rdata <= prop_gain_q;
                    ADDR_INT_GAIN: reg_rdata <= int_gain_q;
                    ADDR_BAUD_DIV: reg_rdata <= baud_div_q;
                    ADDR_PULSE_RATE: reg_rdata <= pulse_rate_q;
                    ADDR_FAULT_NOW: reg_rdata <= {13'h0, fault_q};
                    ADDR_STATUS: reg_rdata <= {13'h0, identify_busy_q, anti_res_enable, latched_q};
                    ADDR_STEP_ANGLE: reg_rdata <= {8'h0, step_angle_q};
                    default: reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // Checks.
    property p_latch_holds;
        @(posedge core_clk) disable iff (reset) latched_q |=> latched_q && !motor_enable;
    endproperty
    a_latch_holds: assert property (p_latch_holds) else $error("fault latch released");
    property p_fault_sets;
        @(posedge core_clk) disable iff (reset) over_current_sense |=> fault_q[0];
    endproperty
    a_fault_sets: assert property (p_fault_sets) else $error("current fault not set");
    property p_supply;
        @(posedge core_clk) disable iff (reset) supply_high_sense |=> fault_q[1];
    endproperty
    a_supply: assert property (p_supply) else $error("supply fault not set");
    property p_wiring;
        @(posedge core_clk) disable iff (reset) wiring_bad_sense |=> fault_q[2];
    endproperty
    a_wiring: assert property (p_wiring) else $error("wiring fault not set");
    property p_clear;
        @(posedge core_clk) disable iff (reset)
            wr_ctl && req.wdata[CTL_CLR_PRESENT] && !over_current_sense |=> !fault_q[0];
    endproperty
    a_clear: assert property (p_clear) else $error("present fault not cleared");
    property p_antires;
        @(posedge core_clk) disable iff (reset)
            (res_q[2].amplitude != 16'h0) |=> anti_res_enable;
    endproperty
    a_antires: assert property (p_antires) else $error("anti-resonance not on");
    property p_persist;
        @(posedge core_clk) disable iff (reset)
            wr_ctl && req.wdata[CTL_PERSIST] |=> persist_parameters ##1 !persist_parameters;
    endproperty
    a_persist: assert property (p_persist) else $error("persist pulse wrong");
    property p_peak_range;
        @(posedge core_clk) disable iff (reset) peak_q >= PEAK_MIN && peak_q <= PEAK_MAX;
    endproperty
    a_peak_range: assert property (p_peak_range) else $error("peak out of range");

endmodule : sdcfl_core
`default_nettype wire

// File: rtl/sdcfl_pkg.sv
package sdcfl_pkg;

    // Register indices on the plain register port.
    localparam logic [4:0] ADDR_CONTROL     = 5'h00;  // Command and mode bits.
    localparam logic [4:0] ADDR_PEAK        = 5'h01;  // Peak coil current, units of 0.1 A.
    localparam logic [4:0] ADDR_MICROSTEP   = 5'h02;  // Microsteps per full step.
    localparam logic [4:0] ADDR_PROP_GAIN   = 5'h03;  // Current loop proportional gain.
    localparam logic [4:0] ADDR_INT_GAIN    = 5'h04;  // Current loop integral gain.
    localparam logic [4:0] ADDR_BAUD_DIV    = 5'h05;  // Tuning link baud divider.
    localparam logic [4:0] ADDR_PULSE_RATE  = 5'h06;  // Internal pulse generator period.
    localparam logic [4:0] ADDR_FAULT_NOW   = 5'h07;  // Present fault flags.
    localparam logic [4:0] ADDR_STATUS      = 5'h08;  // Block status.
    localparam logic [4:0] ADDR_STEP_ANGLE  = 5'h09;  // Detected motor step angle.
    localparam logic [4:0] ADDR_RES_BASE    = 5'h10;  // Resonance areas, four words each.
    localparam logic [4:0] ADDR_HIST_BASE   = 5'h1c;  // Unused base marker.
    localparam logic [3:0] HIST_INDEX_LAST  = 4'h9;   // Index of the oldest history entry.
    localparam logic [7:0] ADDR_HIST_WIN    = 8'h20;  // History window, ten words.

    // Control register bit positions.
    localparam int CTL_CLR_PRESENT = 0;  // Write one: clear present faults.
    localparam int CTL_CLR_ALL     = 1;  // Write one: clear faults and history.
    localparam int CTL_FORMAT      = 2;  // Zero step/direction, one dual pulse.
    localparam int CTL_EDGE        = 3;  // Zero rising, one falling.
    localparam int CTL_PERSIST     = 4;  // Write one: persist parameters.
    localparam int CTL_LOAD_DEF    = 5;  // Write one: load default parameters.
    localparam int CTL_STEP_TEST   = 6;  // Write one: start current step test.
    localparam int CTL_GEN_RUN     = 7;  // Internal pulse generator runs.
    localparam int CTL_CAPTURE     = 8;  // Write one: capture speed into area limit.
    localparam int CTL_CAP_AREA    = 9;  // Two bits: area to capture into.
    localparam int CTL_CAP_UPPER   = 11; // Capture into ceiling when one.

    // Limits and defaults.
    localparam logic [15:0] PEAK_MIN       = 16'h0001;  // 0.1 A.
    localparam logic [15:0] PEAK_MAX       = 16'h0020;  // 3.2 A.
    localparam logic [15:0] MICRO_MIN      = 16'h0001;
    localparam logic [15:0] MICRO_MAX      = 16'h0200;  // 512 microsteps.
    localparam logic [15:0] RES_DEF_ZERO   = 16'h0000;  // Areas one and two.
    localparam logic [15:0] RES_DEF_THREE  = 16'h0080;  // Area three, 128.
    localparam int          CLK_HZ         = 10_000_000;
    localparam int          BAUD_DEFAULT   = 38400;
    localparam logic [15:0] BAUD_DIV_DEF   = 16'(CLK_HZ / BAUD_DEFAULT);
    localparam int          DOUBLE_TOGGLE_MS = 1000;     // Window for two switch changes.
    localparam int          DOUBLE_TOGGLE_CYC = CLK_HZ / 1000 * DOUBLE_TOGGLE_MS;
    localparam int          STEP_TEST_CYC  = 16;         // Length of a current step test.
    localparam logic [15:0] PEAK_DEFAULT   = 16'h0010;
    localparam logic [15:0] MICRO_DEFAULT  = 16'h0010;

    // Fault codes kept in the history.
    typedef enum logic [2:0] {
        SDCFL_FLT_NONE    = 3'h0,
        SDCFL_FLT_CURRENT = 3'h1,
        SDCFL_FLT_SUPPLY  = 3'h2,
        SDCFL_FLT_WIRING  = 3'h4
    } sdcfl_fault_e;

    // One resonance area.
    typedef struct packed {
        logic [15:0] amplitude;
        logic [15:0] phase;
        logic [15:0] speed_floor;
        logic [15:0] speed_ceiling;
    } sdcfl_res_s;

    // Register port request.
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } sdcfl_req_s;

endpackage : sdcfl_pkg

// File: rtl/sdcfl_fault_history.sv
`timescale 1ns/1ns
`default_nettype none
// Ten-deep fault history; entry 0 newest, entry 9 oldest.
module sdcfl_fault_history
    import sdcfl_pkg::*;
#(
    parameter int DEPTH = 10
) (
    // Clock and reset.
    input  wire logic       core_clk,
    input  wire logic       reset,
    // Control.
    input  wire logic       push,
    input  wire logic [2:0] code,
    input  wire logic       clear_all,
    // Readout.
    input  wire logic [3:0] rd_index,
    output logic      [2:0] rd_code
);

    // Storage array of fault codes.
    logic [2:0] entry_q [DEPTH];

    // Shift toward the oldest, drop the last and insert at zero.
    always_ff @(posedge core_clk) begin
        if (reset || clear_all) begin
            for (int i = 0; i < DEPTH; i++) begin
                entry_q[i] <= SDCFL_FLT_NONE;
            end
        end else if (push) begin
            entry_q[0] <= code;
            for (int i = 1; i < DEPTH; i++) begin
                entry_q[i] <= entry_q[i-1];
            end
        end
    end

    // Readout mux; out of range reads zero.
    always_comb begin
        rd_code = SDCFL_FLT_NONE;
        if (32'(rd_index) < DEPTH) begin
            rd_code = entry_q[rd_index];
        end
    end

endmodule : sdcfl_fault_history
`default_nettype wire

// File: rtl/sdcfl_edge_detect.sv
`timescale 1ns/1ns
`default_nettype none
// Picks the selected edge of a step input.
module sdcfl_edge_detect (
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic reset,
    // Input and edge choice.
    input  wire logic level,
    input  wire logic falling,
    // One-cycle edge pulse.
    output logic      edge_pulse
);

    // Previous input level.
    logic prev_q;

    // Track the previous level.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level;
        end
    end

    // Rising or falling edge as selected.
    assign edge_pulse = falling ? (prev_q & ~level) : (~prev_q & level);

endmodule : sdcfl_edge_detect
`default_nettype wire

// File: verification/sdcfl_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
// Motion controller: one six-cycle pulse for each fire request.
module sdcfl_ctrl_model (
    // Clock and request.
    input  wire logic core_clk,
    input  wire logic dual,
    input  wire logic dir_req,
    input  wire logic fire,
    // Command lines.
    output logic      step_pulse_in,
    output logic      direction_in
);
    logic [2:0] n_q = 3'h0;   // Cycles left in the pulse.
    logic       sel_q = 1'b0; // Pulse rides the second line.
    logic       dir_q = 1'b0; // Held direction level.
    // The pulse goes on the line that the chosen format asks for.
    always @(posedge core_clk) begin
        if (fire) begin
            n_q   <= 3'h6;
            sel_q <= dual & dir_req;
            dir_q <= dual ? dir_q : dir_req;
        end else if (n_q != 3'h0) begin
            n_q <= n_q - 3'h1;
        end
    end
    assign step_pulse_in = (n_q != 3'h0) & !sel_q;
    assign direction_in  = dual ? ((n_q != 3'h0) & sel_q) : dir_q;
endmodule : sdcfl_ctrl_model
`default_nettype wire

// File: verification/stepper_drive_config_fault_log_bench.sv
`timescale 1ns/1ns
`default_nettype none
// Register-level tests of the drive configuration and fault log.
module stepper_drive_config_fault_log_bench import sdcfl_pkg::*;;
    logic core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, dual = 1'b0;
    logic fire = 1'b0, dir_req = 1'b0, sw4 = 1'b0, done = 1'b0;
    logic [2:0]  flt_q = 3'h0; // Sensor levels: wiring, supply, current.
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic step_pulse_in, direction_in, step_out, dir_out, motor_enable, anti_res_enable;
    logic identify_start, step_test_start, persist_parameters;
    int miscompares = 0, checks = 0, steps = 0, ids = 0, tests = 0, pers = 0;
    initial forever #50 core_clk = ~core_clk;
    sdcfl_ctrl_model ctrl (.core_clk, .dual, .dir_req, .fire, .step_pulse_in, .direction_in);
    sdcfl_core #(.TOGGLE_WINDOW(50)) dut (.core_clk, .reset, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .step_pulse_in, .direction_in,
        .setting_switch_four(sw4), .over_current_sense(flt_q[0]),
        .supply_high_sense(flt_q[1]), .wiring_bad_sense(flt_q[2]), .identify_done(done),
        .detected_step_angle(8'h32), .step_out, .dir_out, .motor_enable,
        .anti_res_enable, .identify_start, .step_test_start, .persist_parameters);
    // Counts the one-cycle output pulses.
    always @(posedge core_clk) begin
        steps <= steps + int'(step_out);
        ids   <= ids + int'(identify_start);
        tests <= tests + int'(step_test_start);
        pers  <= pers + int'(persist_parameters);
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    // One command pulse; step count checked early and after the trailing edge.
    task automatic pulse(input logic d, input int early, input int total);
        @(posedge core_clk);
        fire    <= 1'b1;
        dir_req <= d;
        @(posedge core_clk);
        fire <= 1'b0;
        repeat (4) @(posedge core_clk);
        #1 chk(16'(steps), 16'(early));
        repeat (6) @(posedge core_clk);
        #1 chk(16'(steps), 16'(total));
        chk({15'h0, dir_out}, {15'h0, d});
    endtask : pulse
    task automatic flt(input logic [2:0] f);
        @(posedge core_clk);
        flt_q <= f;
        @(posedge core_clk);
        flt_q <= 3'h0;
        repeat (3) @(posedge core_clk);
    endtask : flt
    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        rd(ADDR_BAUD_DIV, BAUD_DIV_DEF);
        rd(8'h0f, 16'h0000);
        wr(ADDR_PEAK, 16'h0000);
        wr(ADDR_PEAK, 16'h0021);
        rd(ADDR_PEAK, PEAK_DEFAULT);
        wr(ADDR_PEAK, PEAK_MAX);
        rd(ADDR_PEAK, PEAK_MAX);
        wr(ADDR_MICROSTEP, 16'h0201);
        rd(ADDR_MICROSTEP, MICRO_DEFAULT);
        wr(ADDR_MICROSTEP, MICRO_MAX);
        rd(ADDR_MICROSTEP, MICRO_MAX);
        wr(ADDR_PROP_GAIN, 16'h0005);
        rd(ADDR_PROP_GAIN, 16'h0005);
        $display("test settings done");
        wr(ADDR_CONTROL, 16'h0000);
        pulse(1'b1, 1, 1);
        pulse(1'b0, 2, 2);
        wr(ADDR_CONTROL, 16'h0008);
        pulse(1'b0, 2, 3);
        dual <= 1'b1;
        wr(ADDR_CONTROL, 16'h0004);
        pulse(1'b1, 4, 4);
        pulse(1'b0, 5, 5);
        $display("test stepping done");
        @(posedge core_clk) sw4 <= 1'b1;
        repeat (5) @(posedge core_clk);
        sw4 <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1 chk(16'(ids), 16'h0001);
        @(posedge core_clk) done <= 1'b1;
        @(posedge core_clk);
        done <= 1'b0;
        rd(ADDR_STEP_ANGLE, 16'h0032);
        dual <= 1'b0;
        wr(ADDR_CONTROL, 16'h0010);
        wr(ADDR_CONTROL, 16'h0040);
        repeat (3) @(posedge core_clk);
        #1 chk(16'(pers), 16'h0001);
        chk(16'(tests), 16'h0001);
        wr(ADDR_CONTROL, 16'h0020);
        rd(ADDR_RES_BASE + 5'h8, RES_DEF_THREE);
        rd(ADDR_RES_BASE + 5'h9, RES_DEF_THREE);
        rd(ADDR_RES_BASE + 5'h5, RES_DEF_ZERO);
        chk({15'h0, anti_res_enable}, 16'h0001);
        wr(ADDR_RES_BASE + 5'h8, 16'h0000);
        wr(ADDR_RES_BASE + 5'h9, 16'h0000);
        repeat (2) @(posedge core_clk);
        #1 chk({15'h0, anti_res_enable}, 16'h0000);
        wr(ADDR_PULSE_RATE, 16'h0055);
        wr(ADDR_CONTROL, 16'h0b00);
        rd(ADDR_RES_BASE + 5'h7, 16'h0055);
        wr(ADDR_CONTROL, 16'h0080);
        repeat (150) @(posedge core_clk);
        #1 chk(16'(steps), 16'h0006);
        wr(ADDR_CONTROL, 16'h0000);
        $display("test setup done");
        chk({15'h0, motor_enable}, 16'h0001);
        flt(3'h1);
        rd(ADDR_FAULT_NOW, 16'h0001);
        chk({15'h0, motor_enable}, 16'h0000);
        flt(3'h2);
        rd(ADDR_FAULT_NOW, 16'h0003);
        rd(ADDR_HIST_WIN, 16'h0002);
        wr(ADDR_CONTROL, 16'h0001);
        rd(ADDR_FAULT_NOW, 16'h0000);
        rd(ADDR_HIST_WIN + 8'h1, 16'h0001);
        flt(3'h4);
        rd(ADDR_FAULT_NOW, 16'h0004);
        repeat (7) begin
            wr(ADDR_CONTROL, 16'h0001);
            flt(3'h2);
        end
        rd(ADDR_HIST_WIN + 8'h9, 16'h0001);
        rd(ADDR_HIST_WIN + 8'h7, 16'h0004);
        wr(ADDR_CONTROL, 16'h0002);
        rd(ADDR_FAULT_NOW, 16'h0000);
        rd(ADDR_HIST_WIN + 8'h9, 16'h0000);
        $display("test faults done");
        complete_run();
    end
endmodule : stepper_drive_config_fault_log_bench
`default_nettype wire
